// [hdl/eeprom_pkg.sv]
// constants, types and command decoding for the serial eeprom command engine
package eeprom_pkg;

    localparam int WORDS = 64;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int SYNC_STAGES = 3;

    // bit counter values after the start bit: last address bit, last data bit
    localparam logic [4:0] CNT_A0 = 5'h07;
    localparam logic [4:0] CNT_D0 = 5'h17;

    // settling wait after select falls, lets the command toggle catch up
    localparam logic [2:0] SETTLE_LAST = 3'h5;

    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
    localparam logic WEL_RESET = 1'b0;

    // programming cycle time and the cycle count derived from it
    localparam int PROG_TIME_MS = 15;
    localparam int CLK_MHZ = 100;
    localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_MS * 1000 * CLK_MHZ;

    // opcode and address-msb encodings
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_LOCK = 2'h0;
    localparam logic [1:0] EXT_FILL = 2'h1;
    localparam logic [1:0] EXT_ERASEALL = 2'h2;
    localparam logic [1:0] EXT_UNLOCK = 2'h3;

    typedef enum logic [2:0] {
        K_READ = 3'b000,
        K_WRITE = 3'b001,
        K_ERASE = 3'b010,
        K_UNLOCK = 3'b011,
        K_FILL = 3'b100,
        K_LOCK = 3'b101,
        K_ERASEALL = 3'b110
    } kind_t;

    typedef struct packed {
        logic [1:0] op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;

    // opcode plus the two address msbs name the command
    function automatic kind_t decodeKind(input logic [1:0] op,
                                         input logic [1:0] hi);
        kind_t k;
        k = K_LOCK;
        case (op)
            OP_READ: k = K_READ;
            OP_WRITE: k = K_WRITE;
            OP_ERASE: k = K_ERASE;
            default: begin
                case (hi)
                    EXT_UNLOCK: k = K_UNLOCK;
                    EXT_FILL: k = K_FILL;
                    EXT_ERASEALL: k = K_ERASEALL;
                    default: k = K_LOCK;
                endcase
            end
        endcase
        return k;
    endfunction

    function automatic logic hasData(input kind_t k);
        return (k == K_WRITE) || (k == K_FILL);
    endfunction

    function automatic logic isProg(input kind_t k);
        return (k == K_WRITE) || (k == K_FILL) || (k == K_ERASE) ||
               (k == K_ERASEALL);
    endfunction

endpackage

// [hdl/serial_eeprom_command_engine.sv]
// serial eeprom command engine: link decoder, programming timer and array
module serial_eeprom_command_engine import eeprom_pkg::*; #(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic deviceSelect,
    input wire logic serialClockIn,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn
);

    typedef enum logic [2:0] {
        L_WAIT = 3'b000,
        L_CMD = 3'b001,
        L_READ = 3'b010,
        L_DONE = 3'b011,
        L_VOID = 3'b100
    } link_state_t;

    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_SETTLE = 2'b01,
        C_PROG = 2'b10
    } ctl_state_t;

    localparam int SY_DONE = 0;
    localparam int SY_START = 1;
    localparam int SY_SEL = 2;

    // array, written only in the clk domain
    logic [DATA_W-1:0] mem_r [WORDS];

    // link domain
    logic linkRst;
    link_state_t linkState_r;
    logic [4:0] bitCnt_r;
    logic [22:0] inSr_r;
    logic [DATA_W-1:0] outSr_r;
    logic outBit_r;
    logic readActive_r;
    logic startTgl_r;
    logic doneTgl_r;
    cmd_t cmdHeld_r;
    kind_t kindA0;
    logic [ADDR_W-1:0] addrA0;
    logic atA0;
    logic atD0;
    logic startEvt;
    logic finishEvt;
    logic withdrawEvt;

    // clk domain
    logic [2:0] sync_r [SYNC_STAGES];
    logic [2:0] stable_r;
    logic [2:0] stable_nxt;
    logic [2:0] stableChg;
    logic selFall;
    logic startSeen;
    ctl_state_t ctlState_r;
    logic [2:0] settleCnt_r;
    logic [31:0] progCnt_r;
    logic doneAck_r;
    logic wel_r;
    logic busy_r;
    logic statusShow_r;
    cmd_t progCmd_r;
    kind_t progKind_r;
    kind_t execKind;
    logic execNow;
    logic progStart;
    logic progEnd;

    ////////////////////////////////////////////////////////////////////////
    // link side, clocked by the host's serial clock

    // deselect holds the decoder in reset so every frame restarts clean
    assign linkRst = rst | ~deviceSelect;

    assign kindA0 = decodeKind(inSr_r[6:5], inSr_r[4:3]);
    assign addrA0 = {inSr_r[4:0], serialIn};
    assign atA0 = (linkState_r == L_CMD) && (bitCnt_r == CNT_A0);
    assign atD0 = (linkState_r == L_CMD) && (bitCnt_r == CNT_D0);
    assign startEvt = deviceSelect && (linkState_r == L_WAIT) && serialIn;
    assign finishEvt = deviceSelect &&
        ((atA0 && kindA0 != K_READ && !hasData(kindA0)) || atD0);
    // a clock after the last bit means select fell too late: drop the command
    assign withdrawEvt = deviceSelect && (linkState_r == L_DONE);

    // bit decoder: start bit, opcode, address, optional data
    always_ff @(posedge serialClockIn or posedge linkRst) begin
        if (linkRst) begin
            linkState_r <= L_WAIT;
            bitCnt_r <= 5'h00;
            inSr_r <= 23'h000000;
        end else begin
            case (linkState_r)
                L_WAIT: begin
                    if (serialIn) begin
                        linkState_r <= L_CMD;
                    end
                    bitCnt_r <= 5'h00;
                end
                L_CMD: begin
                    inSr_r <= {inSr_r[21:0], serialIn};
                    bitCnt_r <= bitCnt_r + 5'h01;
                    if (atA0) begin
                        if (kindA0 == K_READ) begin
                            linkState_r <= L_READ;
                        end else if (!hasData(kindA0)) begin
                            linkState_r <= L_DONE;
                        end
                    end else if (atD0) begin
                        linkState_r <= L_DONE;
                    end
                end
                L_DONE: linkState_r <= L_VOID;
                L_READ: linkState_r <= L_READ;
                L_VOID: linkState_r <= L_VOID;
                default: linkState_r <= L_WAIT;
            endcase
        end
    end

    // read shifter; the word is read across domains but is quiet
    // unless a program cycle runs, which the host must not overlap
    always_ff @(posedge serialClockIn or posedge linkRst) begin
        if (linkRst) begin
            readActive_r <= 1'b0;
            outSr_r <= '0;
            outBit_r <= 1'b0;
        end else if (atA0 && kindA0 == K_READ) begin
            readActive_r <= 1'b1;
            outSr_r <= mem_r[addrA0];
            outBit_r <= 1'b0;
        end else if (readActive_r) begin
            outBit_r <= outSr_r[DATA_W-1];
            outSr_r <= {outSr_r[DATA_W-2:0], 1'b0};
        end
    end

    // toggles and held command survive deselect for the clk domain
    always_ff @(posedge serialClockIn or posedge rst) begin
        if (rst) begin
            startTgl_r <= 1'b0;
            doneTgl_r <= 1'b0;
            cmdHeld_r <= '0;
        end else begin
            if (startEvt) begin
                startTgl_r <= ~startTgl_r;
            end
            if (finishEvt || withdrawEvt) begin
                doneTgl_r <= ~doneTgl_r;
            end
            if (finishEvt && atA0) begin
                cmdHeld_r <= '{op: inSr_r[6:5], addr: addrA0, data: '0};
            end else if (finishEvt) begin
                cmdHeld_r <= '{op: inSr_r[22:21], addr: inSr_r[20:15],
                               data: {inSr_r[14:0], serialIn}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossing into clk: three stages, a change counts once 2 and 3 agree

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_r[i] <= 3'h0;
            end
        end else begin
            sync_r[0] <= {deviceSelect, startTgl_r, doneTgl_r};
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_r[i] <= sync_r[i-1];
            end
        end
    end

    assign stable_nxt = (sync_r[1] & sync_r[2]) |
                        (stable_r & (sync_r[1] ^ sync_r[2]));
    assign stableChg = stable_r ^ stable_nxt;
    assign selFall = stableChg[SY_SEL] & ~stable_nxt[SY_SEL];
    assign startSeen = stableChg[SY_START];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stable_r <= 3'h0;
        end else begin
            stable_r <= stable_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command execution and programming timer

    assign execKind = decodeKind(cmdHeld_r.op, cmdHeld_r.addr[5:4]);
    assign execNow = (ctlState_r == C_SETTLE) &&
                     (settleCnt_r == SETTLE_LAST) &&
                     (stable_r[SY_DONE] != doneAck_r);
    assign progStart = execNow && isProg(execKind) && wel_r;
    assign progEnd = (ctlState_r == C_PROG) &&
                     (progCnt_r == PROG_CYCLES - 1);

    // a select fall only acts when idle; toggling it while busy is inert
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctlState_r <= C_IDLE;
            settleCnt_r <= 3'h0;
            progCnt_r <= 32'h0;
            doneAck_r <= 1'b0;
        end else begin
            case (ctlState_r)
                C_IDLE: begin
                    settleCnt_r <= 3'h0;
                    if (selFall) begin
                        ctlState_r <= C_SETTLE;
                    end
                end
                C_SETTLE: begin
                    settleCnt_r <= settleCnt_r + 3'h1;
                    if (settleCnt_r == SETTLE_LAST) begin
                        doneAck_r <= stable_r[SY_DONE];
                        ctlState_r <= progStart ? C_PROG : C_IDLE;
                    end
                    progCnt_r <= 32'h0;
                end
                C_PROG: begin
                    // commands sent while busy are consumed, never run
                    doneAck_r <= stable_r[SY_DONE];
                    progCnt_r <= progCnt_r + 32'h1;
                    if (progEnd) begin
                        ctlState_r <= C_IDLE;
                    end
                end
                default: ctlState_r <= C_IDLE;
            endcase
        end
    end

    // write-enable latch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wel_r <= WEL_RESET;
        end else if (execNow && execKind == K_UNLOCK) begin
            wel_r <= 1'b1;
        end else if (execNow && execKind == K_LOCK) begin
            wel_r <= 1'b0;
        end
    end

    // busy and the status display; a new program start wins over a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            statusShow_r <= 1'b0;
            progCmd_r <= '0;
            progKind_r <= K_READ;
        end else begin
            if (progStart) begin
                busy_r <= 1'b1;
                progCmd_r <= cmdHeld_r;
                progKind_r <= execKind;
            end else if (progEnd) begin
                busy_r <= 1'b0;
            end
            if (progStart) begin
                statusShow_r <= 1'b1;
            end else if (startSeen && !busy_r) begin
                statusShow_r <= 1'b0;
            end
        end
    end

    // array update at the end of the cycle; reset models an erased part
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int w = 0; w < WORDS; w++) begin
                mem_r[w] <= ERASED_WORD;
            end
        end else if (progEnd) begin
            case (progKind_r)
                K_WRITE: mem_r[progCmd_r.addr] <= progCmd_r.data;
                K_ERASE: mem_r[progCmd_r.addr] <= ERASED_WORD;
                K_ERASEALL: begin
                    for (int w = 0; w < WORDS; w++) begin
                        mem_r[w] <= ERASED_WORD;
                    end
                end
                K_FILL: begin
                    for (int w = 0; w < WORDS; w++) begin
                        mem_r[w] <= progCmd_r.data;
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive: status takes the pin over read data until cleared

    assign serialOut = statusShow_r ? ~busy_r : outBit_r;
    assign serialOutEn = deviceSelect & (statusShow_r | readActive_r);

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_welReset;
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> !wel_r;
    endproperty
    a_welReset: assert property (p_welReset)
        else $error("write latch set after reset");

    property p_unlock;
        @(posedge clk) disable iff (rst)
        execNow && execKind == K_UNLOCK |=> wel_r;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock did not set latch");

    property p_lock;
        @(posedge clk) disable iff (rst)
        execNow && execKind == K_LOCK |=> !wel_r ##1 !wel_r;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock did not clear latch");

    property p_guarded;
        @(posedge clk) disable iff (rst)
        $rose(busy_r) |-> $past(wel_r) && $past(ctlState_r) == C_SETTLE;
    endproperty
    a_guarded: assert property (p_guarded)
        else $error("programming started without write enable");

    property p_progLen;
        @(posedge clk) disable iff (rst)
        busy_r && progCnt_r == PROG_CYCLES - 1 |=> !busy_r && !$rose(busy_r);
    endproperty
    a_progLen: assert property (p_progLen)
        else $error("busy did not end with the timer");

    property p_erase;
        @(posedge clk) disable iff (rst)
        progEnd && progKind_r == K_ERASE |=>
            mem_r[$past(progCmd_r.addr)] == ERASED_WORD;
    endproperty
    a_erase: assert property (p_erase)
        else $error("erased word not all ones");

    property p_eraseAll;
        @(posedge clk) disable iff (rst)
        progEnd && progKind_r == K_ERASEALL |=>
            mem_r[0] == ERASED_WORD && mem_r[WORDS-1] == ERASED_WORD;
    endproperty
    a_eraseAll: assert property (p_eraseAll)
        else $error("erase all left a word unerased");

    property p_fill;
        @(posedge clk) disable iff (rst)
        progEnd && progKind_r == K_FILL |=>
            mem_r[0] == $past(progCmd_r.data) && mem_r[WORDS-1] == mem_r[0];
    endproperty
    a_fill: assert property (p_fill)
        else $error("fill all pattern missing");

    property p_status;
        @(posedge clk) disable iff (rst)
        deviceSelect && statusShow_r |->
            serialOutEn && serialOut == (ctlState_r != C_PROG);
    endproperty
    a_status: assert property (p_status)
        else $error("status level wrong on output");

    property p_float;
        @(posedge clk) disable iff (rst)
        !deviceSelect |-> !serialOutEn;
    endproperty
    a_float: assert property (p_float)
        else $error("output driven while deselected");

    property p_dummy;
        @(posedge serialClockIn) disable iff (linkRst)
        atA0 && kindA0 == K_READ |=> readActive_r && !outBit_r;
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("dummy zero missing before read word");

    property p_msbFirst;
        @(posedge serialClockIn) disable iff (linkRst)
        atA0 && kindA0 == K_READ |=> ##1 outBit_r == $past(outSr_r[15]);
    endproperty
    a_msbFirst: assert property (p_msbFirst)
        else $error("read word not sent msb first");

    property p_zeros;
        @(posedge serialClockIn) disable iff (linkRst)
        linkState_r == L_WAIT && !serialIn |=> linkState_r == L_WAIT;
    endproperty
    a_zeros: assert property (p_zeros)
        else $error("leading zero taken as start");

endmodule

// [bench/host_master.sv]
// host model: drives select, serial clock and serial input of the engine
module host_master (
    input wire logic clk,
    output logic deviceSelect,
    output logic serialClockIn,
    output logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn
);
    timeunit 1ns;
    timeprecision 1ps;

    // a released pin reads back inverted, so an undriven bit cannot pass
    logic pinSeen;
    assign pinSeen = serialOutEn ? serialOut : ~serialOut;

    // idle bus: deselected, serial clock parked low
    initial begin
        deviceSelect = 1'b0;
        serialClockIn = 1'b0;
        serialIn = 1'b0;
    end

    // one 6 ns serial clock period; the clock only runs inside frames
    task automatic pulse();
        #3 serialClockIn = 1'b1;
        #3 serialClockIn = 1'b0;
    endtask

    // shift nb bits msb first, then the dummy bit and 16 read bits
    task automatic xfer(input logic [31:0] bits, input int nb,
                        input logic rdOn, output logic [16:0] rd);
        rd = '0;
        @(negedge clk);
        deviceSelect = 1'b1;
        for (int i = nb - 1; i >= 0; i--) begin
            serialIn = bits[i];
            pulse();
        end
        if (rdOn) begin
            rd[16] = pinSeen;
            for (int j = 15; j >= 0; j--) begin
                serialIn = ~serialIn;
                pulse();
                rd[j] = pinSeen;
            end
        end
        // drop select before any further clock edge
        @(negedge clk);
        deviceSelect = 1'b0;
        serialIn = ~serialIn;
        repeat (20) @(negedge clk);
    endtask

    // status poll: select only, no serial clock needed
    task automatic poll(output logic [1:0] st);
        @(negedge clk);
        deviceSelect = 1'b1;
        repeat (4) @(negedge clk);
        st = {serialOutEn, pinSeen};
        deviceSelect = 1'b0;
        repeat (20) @(negedge clk);
    endtask
endmodule

// [bench/tb_top.sv]
// self-checking bench for the serial eeprom command engine
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import eeprom_pkg::*;

    localparam int unsigned PROG = 100;
    logic clk, rst, deviceSelect, serialClockIn, serialIn;
    logic serialOut, serialOutEn, wel;
    int mismatches = 0;
    int testsRun = 0;
    logic [31:0] seed = 32'h12d574f8;
    logic [DATA_W-1:0] mem [WORDS];
    logic [16:0] rd;
    logic [1:0] st;
    logic [5:0] a;
    logic [15:0] d;

    serial_eeprom_command_engine #(
        .PROG_CYCLES(PROG)
    ) i_serial_eeprom_command_engine (
        .clk(clk), .rst(rst), .deviceSelect(deviceSelect),
        .serialClockIn(serialClockIn), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn)
    );

    host_master i_host_master (
        .clk(clk), .deviceSelect(deviceSelect),
        .serialClockIn(serialClockIn), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // random source and reference model
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic draw();
        logic [31:0] r;
        r = rnd();
        a = r[5:0];
        d = r[21:6];
    endtask

    // updates the reference copy; 1 when programming should start
    function automatic logic model(input logic [1:0] op,
                                   input logic [5:0] ad,
                                   input logic [15:0] dt);
        logic [1:0] hi;
        logic prog;
        hi = ad[5:4];
        prog = wel && op != 2'h2 && !(op == 2'h0 && hi[1] == hi[0]);
        if (op == 2'h1 && wel) mem[ad] = dt;
        if (op == 2'h3 && wel) mem[ad] = 16'hffff;
        if (op == 2'h0 && hi == 2'h1 && wel) begin
            foreach (mem[i]) mem[i] = dt;
        end
        if (op == 2'h0 && hi == 2'h2 && wel) begin
            foreach (mem[i]) mem[i] = 16'hffff;
        end
        if (op == 2'h0 && hi == 2'h3) wel = 1'b1;
        if (op == 2'h0 && hi == 2'h0) wel = 1'b0;
        return prog;
    endfunction

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // frame helpers; up to three leading zeros precede each start bit
    task automatic send(input logic [1:0] op, input logic [5:0] ad,
                        input logic [15:0] dt, input logic isRead);
        logic [31:0] bits;
        int nb;
        nb = 9 + int'(rnd() % 32'h4);
        bits = {23'h0, 1'b1, op, ad};
        if (op == 2'h1 || (op == 2'h0 && ad[5:4] == 2'h1)) begin
            bits = {7'h0, 1'b1, op, ad, dt};
            nb = nb + 16;
        end
        i_host_master.xfer(bits, nb, isRead, rd);
    endtask

    task automatic readChk(input logic [5:0] ad);
        send(2'h2, ad, 16'h0, 1'b1);
        check(rd, {1'b0, mem[ad]});
        check({16'h0, serialOutEn}, 17'h0);
    endtask

    // issue a command, then follow its status by polling
    task automatic progRun(input logic [1:0] op, input logic [5:0] ad,
                           input logic [15:0] dt);
        logic busy;
        busy = model(op, ad, dt);
        send(op, ad, dt, 1'b0);
        repeat (15) @(negedge clk);
        i_host_master.poll(st);
        if (busy) begin
            check({15'h0, st}, 17'h2);
            i_host_master.poll(st);
            check({15'h0, st}, 17'h2);
            repeat (PROG) @(negedge clk);
            i_host_master.poll(st);
            check({15'h0, st}, 17'h3);
        end else begin
            check({16'h0, st[1]}, 17'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        wel = 1'b0;
        foreach (mem[i]) mem[i] = 16'hffff;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        draw();
        readChk(a);
        progRun(2'h1, a, d);
        readChk(a);
        progRun(2'h0, {2'h3, a[3:0]}, d);
        progRun(2'h1, a, d);
        readChk(a);
        i_host_master.poll(st);
        check({16'h0, st[1]}, 17'h0);
        // write frame cut short by deselect must not program
        i_host_master.xfer({15'h0, 1'b1, 2'h1, ~a, d[15:8]}, 17, 1'b0, rd);
        i_host_master.poll(st);
        check({16'h0, st[1]}, 17'h0);
        readChk(~a);
        // one clock too many after the data: the write is withdrawn
        i_host_master.xfer({6'h0, 1'b1, 2'h1, ~a, d, 1'b0}, 26, 1'b0, rd);
        i_host_master.poll(st);
        check({16'h0, st[1]}, 17'h0);
        readChk(~a);
        for (int i = 0; i < 6; i++) begin
            draw();
            progRun(2'h1, a, d);
            readChk(a);
        end
        progRun(2'h3, a, d);
        readChk(a);
        draw();
        progRun(2'h0, {2'h1, a[3:0]}, d);
        readChk(6'h00);
        readChk(6'h3f);
        progRun(2'h0, {2'h2, a[3:0]}, d);
        readChk(a);
        progRun(2'h0, {2'h0, a[3:0]}, d);
        draw();
        progRun(2'h1, a, d);
        readChk(a);
        end_of_test();
    end

    // watchdog well beyond the expected run length
    initial begin
        #500000;
        mismatches++;
        end_of_test();
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
endmodule
